// ==== hdl/oafe_map.svh ====
// Functional notes
// - Mode field 00/10 external, 01 AC coupling, 11 DC coupling.
// - Five switch bits 4..0; one closes the switch, zero opens it.
// - Two six-bit resistor codes, resistance equals code times 100 kilohm.
// - Third resistor field 00..11 selects 10, 20, 30, 40 kilohm.
// - Amplifier control bit 6 enables the amplifier when one.
// - Bandwidth field 00 5 kHz, 01 40 kHz, 10 600 kHz, 11 2 MHz.
// - Status bit 5 follows amplifier output in calibration, else reads low.
// - Offset bit 7 zero normal, one selects offset calibration mode.
// - Offset bit 6 picks calibration reference, zero negative, one positive input.
// - Six-bit trim field resets to 100000, other offset bits reset zero.
// - Calibration mode with reference one enters calibration, switches zero and two closed.
// - Unimplemented bits read zero and ignore writes.
`ifndef OAFE_MAP_SVH
`define OAFE_MAP_SVH
`define OAFE_OFS_SWITCH    12'h000
`define OAFE_OFS_RES0      12'h004
`define OAFE_OFS_RES1      12'h008
`define OAFE_OFS_AMP0      12'h00C
`define OAFE_OFS_AMP1      12'h010
`define OAFE_OFS_TRIM0     12'h014
`define OAFE_OFS_TRIM1     12'h018
`define OAFE_MASK_SWITCH   8'h7F
`define OAFE_MASK_RES0     8'h3F
`define OAFE_MASK_RES1     8'hFF
`define OAFE_MASK_AMP_WR   8'h43
`define OAFE_MASK_TRIM     8'hFF
`define OAFE_RST_SWITCH    8'h00
`define OAFE_RST_RES       8'h00
`define OAFE_RST_AMP       8'h00
`define OAFE_RST_TRIM      8'h20
`define OAFE_BIT_AMP_EN    6
`define OAFE_BIT_AMP_STAT  5
`define OAFE_BIT_CAL_MODE  7
`define OAFE_BIT_CAL_REF   6
`endif

// ==== hdl/oafe_pkg.sv ====
package oafe_pkg;
	typedef enum logic [1:0] {
		OAFE_CPL_EXT0 = 2'h0,
		OAFE_CPL_AC   = 2'h1,
		OAFE_CPL_EXT1 = 2'h2,
		OAFE_CPL_DC   = 2'h3
	} oafe_cpl_t;
	typedef enum logic [3:0] {
		OAFE_CPL_SEL_EXT = 4'h1,
		OAFE_CPL_SEL_AC  = 4'h2,
		OAFE_CPL_SEL_DC  = 4'h4
	} oafe_cpl_sel_t;
	typedef enum logic [2:0] {
		OAFE_ST_NORMAL = 3'h1,
		OAFE_ST_CALREF = 3'h2,
		OAFE_ST_CALNEG = 3'h4
	} oafe_amp_st_t;
	// Per-amplifier analog controls
	typedef struct packed {
		logic       enable;
		logic [3:0] bw_onehot;
		logic       cal_active;
		logic       ref_positive;
		logic [5:0] trim_code;
	} oafe_amp_ctl_t;
	// Switch fabric and resistor controls
	typedef struct packed {
		logic [2:0] coupling_onehot;
		logic [4:0] switch_close;
		logic [5:0] first_resistor_code;
		logic [5:0] second_resistor_code;
		logic [3:0] third_resistor_onehot;
	} oafe_net_ctl_t;
endpackage

// ==== hdl/oafe_amp_ctl.sv ====
`timescale 1ns/1ps
`include "oafe_map.svh"
// One amplifier channel: decodes its control and offset registers
module oafe_amp_ctl (
	input  wire logic                   ref_clk,
	input  wire logic                   resetn,
	input  wire logic [7:0]             amp_reg,
	input  wire logic [7:0]             trim_reg,
	input  wire logic                   amp_out_raw,
	output oafe_pkg::oafe_amp_ctl_t     amp_ctl,
	output logic                        amp_output_status,
	output oafe_pkg::oafe_amp_st_t      amp_state
);
	oafe_pkg::oafe_amp_st_t state_r;
	oafe_pkg::oafe_amp_st_t state_nxt;
	logic                   offset_cal_mode;
	logic                   cal_reference_sel;

	assign offset_cal_mode   = trim_reg[`OAFE_BIT_CAL_MODE];
	assign cal_reference_sel = trim_reg[`OAFE_BIT_CAL_REF];

	// Track calibration phase; the reference pick only matters while calibrating
	always_comb begin
		state_nxt = oafe_pkg::OAFE_ST_NORMAL;
		if (offset_cal_mode) begin
			state_nxt = cal_reference_sel ? oafe_pkg::OAFE_ST_CALREF : oafe_pkg::OAFE_ST_CALNEG;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state_r <= oafe_pkg::OAFE_ST_NORMAL;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Controls are combinational from registers, so they follow a write by one edge
	always_comb begin
		amp_ctl.enable       = amp_reg[`OAFE_BIT_AMP_EN];
		amp_ctl.bw_onehot    = 4'h1 << amp_reg[1:0];
		amp_ctl.cal_active   = offset_cal_mode;
		amp_ctl.ref_positive = cal_reference_sel;
		amp_ctl.trim_code    = trim_reg[5:0];
	end

	// Comparator result masked low outside calibration
	assign amp_output_status = offset_cal_mode & amp_out_raw;
	assign amp_state         = state_r;
endmodule

// ==== hdl/oafe_net_ctl.sv ====
`timescale 1ns/1ps
// Switch fabric decode: coupling mode, switches and resistor selections
module oafe_net_ctl (
	input  wire logic [7:0]         switch_reg,
	input  wire logic [7:0]         res0_reg,
	input  wire logic [7:0]         res1_reg,
	input  wire logic               cal_any,
	output oafe_pkg::oafe_net_ctl_t net_ctl
);
	oafe_pkg::oafe_cpl_t coupling_mode_sel;

	assign coupling_mode_sel = oafe_pkg::oafe_cpl_t'(switch_reg[6:5]);

	always_comb begin
		unique case (coupling_mode_sel)
			oafe_pkg::OAFE_CPL_AC: net_ctl.coupling_onehot = 3'h2;
			oafe_pkg::OAFE_CPL_DC: net_ctl.coupling_onehot = 3'h4;
			default:               net_ctl.coupling_onehot = 3'h1;
		endcase
		// Calibration forces switches zero and two closed
		net_ctl.switch_close         = switch_reg[4:0] | {2'h0, cal_any, 1'h0, cal_any};
		net_ctl.first_resistor_code  = res0_reg[5:0];
		net_ctl.second_resistor_code = res1_reg[5:0];
		net_ctl.third_resistor_onehot = 4'h1 << res1_reg[7:6];
	end
endmodule

// ==== hdl/oafe_regs.sv ====
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "oafe_map.svh"
// APB register bank for the optical front end; zero wait states
module oafe_regs (
	input  wire logic               ref_clk,
	input  wire logic               resetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic [1:0]         amp_out_raw,
	output oafe_pkg::oafe_net_ctl_t net_ctl,
	output oafe_pkg::oafe_amp_ctl_t amp0_ctl,
	output oafe_pkg::oafe_amp_ctl_t amp1_ctl
);
	logic [7:0]  sw_r;
	logic [7:0]  sw_nxt;
	logic [7:0]  res0_r;
	logic [7:0]  res0_nxt;
	logic [7:0]  res1_r;
	logic [7:0]  res1_nxt;
	logic [7:0]  amp0_r;
	logic [7:0]  amp0_nxt;
	logic [7:0]  amp1_r;
	logic [7:0]  amp1_nxt;
	logic [7:0]  trim0_r;
	logic [7:0]  trim0_nxt;
	logic [7:0]  trim1_r;
	logic [7:0]  trim1_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        wr_en;
	logic        rd_en;
	logic        hit;
	logic [1:0]  stat;
	oafe_pkg::oafe_amp_st_t st0;
	oafe_pkg::oafe_amp_st_t st1;

	// Masked write so unimplemented bits stay zero
	function automatic logic [7:0] mwr(input logic [7:0] old, input logic [7:0] mask);
		mwr = pstrb[0] ? (pwdata[7:0] & mask) : old;
	endfunction

	// Control register read value; bit 5 is the live status and is never stored
	function automatic logic [7:0] amp_rd(input logic [7:0] ctl, input logic status);
		amp_rd = ctl | {2'h0, status, 5'h0};
	endfunction

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & ~pwrite & ~penable;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata  = prdata_r;

	always_comb begin
		unique case (paddr)
			`OAFE_OFS_SWITCH, `OAFE_OFS_RES0, `OAFE_OFS_RES1, `OAFE_OFS_AMP0,
			`OAFE_OFS_AMP1, `OAFE_OFS_TRIM0, `OAFE_OFS_TRIM1: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// Register next values
	always_comb begin
		sw_nxt    = sw_r;
		res0_nxt  = res0_r;
		res1_nxt  = res1_r;
		amp0_nxt  = amp0_r;
		amp1_nxt  = amp1_r;
		trim0_nxt = trim0_r;
		trim1_nxt = trim1_r;
		if (wr_en) begin
			unique case (paddr)
				`OAFE_OFS_SWITCH: sw_nxt    = mwr(sw_r, `OAFE_MASK_SWITCH);
				`OAFE_OFS_RES0:   res0_nxt  = mwr(res0_r, `OAFE_MASK_RES0);
				`OAFE_OFS_RES1:   res1_nxt  = mwr(res1_r, `OAFE_MASK_RES1);
				`OAFE_OFS_AMP0:   amp0_nxt  = mwr(amp0_r, `OAFE_MASK_AMP_WR);
				`OAFE_OFS_AMP1:   amp1_nxt  = mwr(amp1_r, `OAFE_MASK_AMP_WR);
				`OAFE_OFS_TRIM0:  trim0_nxt = mwr(trim0_r, `OAFE_MASK_TRIM);
				`OAFE_OFS_TRIM1:  trim1_nxt = mwr(trim1_r, `OAFE_MASK_TRIM);
				default: ;
			endcase
		end
	end

	// Read data captured in setup so it is stable through the access phase
	always_comb begin
		prdata_nxt = prdata_r;
		if (rd_en) begin
			unique case (paddr)
				`OAFE_OFS_SWITCH: prdata_nxt = {24'h0, sw_r};
				`OAFE_OFS_RES0:   prdata_nxt = {24'h0, res0_r};
				`OAFE_OFS_RES1:   prdata_nxt = {24'h0, res1_r};
				`OAFE_OFS_AMP0:   prdata_nxt = {24'h0, amp_rd(amp0_r, stat[0])};
				`OAFE_OFS_AMP1:   prdata_nxt = {24'h0, amp_rd(amp1_r, stat[1])};
				`OAFE_OFS_TRIM0:  prdata_nxt = {24'h0, trim0_r};
				`OAFE_OFS_TRIM1:  prdata_nxt = {24'h0, trim1_r};
				default:          prdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sw_r     <= `OAFE_RST_SWITCH;
			res0_r   <= `OAFE_RST_RES;
			res1_r   <= `OAFE_RST_RES;
			amp0_r   <= `OAFE_RST_AMP;
			amp1_r   <= `OAFE_RST_AMP;
			trim0_r  <= `OAFE_RST_TRIM;
			trim1_r  <= `OAFE_RST_TRIM;
			prdata_r <= 32'h0;
		end else begin
			sw_r     <= sw_nxt;
			res0_r   <= res0_nxt;
			res1_r   <= res1_nxt;
			amp0_r   <= amp0_nxt;
			amp1_r   <= amp1_nxt;
			trim0_r  <= trim0_nxt;
			trim1_r  <= trim1_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	oafe_amp_ctl u_amp0 (
		.ref_clk           (ref_clk),
		.resetn            (resetn),
		.amp_reg           (amp0_r),
		.trim_reg          (trim0_r),
		.amp_out_raw       (amp_out_raw[0]),
		.amp_ctl           (amp0_ctl),
		.amp_output_status (stat[0]),
		.amp_state         (st0)
	);

	oafe_amp_ctl u_amp1 (
		.ref_clk           (ref_clk),
		.resetn            (resetn),
		.amp_reg           (amp1_r),
		.trim_reg          (trim1_r),
		.amp_out_raw       (amp_out_raw[1]),
		.amp_ctl           (amp1_ctl),
		.amp_output_status (stat[1]),
		.amp_state         (st1)
	);

	oafe_net_ctl u_net (
		.switch_reg (sw_r),
		.res0_reg   (res0_r),
		.res1_reg   (res1_r),
		.cal_any    (trim0_r[7] | trim1_r[7]),
		.net_ctl    (net_ctl)
	);

	// Checks
	a_trim_reset: assert property (@(posedge ref_clk) $rose(resetn) |-> trim0_r == 8'h20 && trim1_r == 8'h20)
		else $error("trim reset value wrong");
	a_write_lands: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_en && pstrb[0] && paddr == `OAFE_OFS_TRIM0 |=> amp0_ctl.trim_code == $past(pwdata[5:0]))
		else $error("trim write not applied");
	a_status_low: assert property (@(posedge ref_clk) disable iff (!resetn)
		rd_en && paddr == `OAFE_OFS_AMP0 && !trim0_r[7] |=> prdata_r[5] == 1'b0)
		else $error("status not low in normal mode");
	a_status_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
		rd_en && paddr == `OAFE_OFS_AMP1 && trim1_r[7] |=> prdata_r[5] == $past(amp_out_raw[1]))
		else $error("status not following output");
	a_cal_switches: assert property (@(posedge ref_clk) disable iff (!resetn)
		trim0_r[7] |-> net_ctl.switch_close[0] && net_ctl.switch_close[2])
		else $error("calibration switches open");
	a_cal_state: assert property (@(posedge ref_clk) disable iff (!resetn)
		trim0_r[7] && trim0_r[6] ##1 trim0_r[7] && trim0_r[6] |-> st0 == oafe_pkg::OAFE_ST_CALREF)
		else $error("calibration state not entered");
	a_unused_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
		sw_r[7] == 1'b0 && res0_r[7:6] == 2'h0 && amp0_r[7] == 1'b0 && amp0_r[5:2] == 4'h0 &&
		amp1_r[7] == 1'b0 && amp1_r[5:2] == 4'h0)
		else $error("unimplemented bit set");
	a_coupling_dec: assert property (@(posedge ref_clk) disable iff (!resetn)
		sw_r[6:5] == 2'h2 |-> net_ctl.coupling_onehot == 3'h1)
		else $error("coupling decode wrong");
	a_amp_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
		amp1_ctl.enable == amp1_r[6] && amp1_ctl.bw_onehot == {amp1_r[1:0] == 2'h3, amp1_r[1:0] == 2'h2,
		amp1_r[1:0] == 2'h1, amp1_r[1:0] == 2'h0})
		else $error("amplifier controls wrong");
	a_third_res: assert property (@(posedge ref_clk) disable iff (!resetn)
		net_ctl.third_resistor_onehot == {res1_r[7:6] == 2'h3, res1_r[7:6] == 2'h2, res1_r[7:6] == 2'h1,
		res1_r[7:6] == 2'h0})
		else $error("third resistor decode wrong");

	// Every coupling code; both external codes decode alike
	a_coupling_ext: assert property (@(posedge ref_clk) disable iff (!resetn)
		sw_r[6:5] == 2'h0 |-> net_ctl.coupling_onehot == 3'h1)
		else $error("external coupling decode wrong");
	a_coupling_ac: assert property (@(posedge ref_clk) disable iff (!resetn)
		sw_r[6:5] == 2'h1 |-> net_ctl.coupling_onehot == 3'h2)
		else $error("AC coupling decode wrong");
	a_coupling_dc: assert property (@(posedge ref_clk) disable iff (!resetn)
		sw_r[6:5] == 2'h3 |-> net_ctl.coupling_onehot == 3'h4)
		else $error("DC coupling decode wrong");

	// Switches follow software outside calibration; either channel forces zero and two
	a_switch_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
		!trim0_r[7] && !trim1_r[7] |-> net_ctl.switch_close == sw_r[4:0])
		else $error("switch state not following register");
	a_cal1_switches: assert property (@(posedge ref_clk) disable iff (!resetn)
		trim1_r[7] |-> net_ctl.switch_close[0] && net_ctl.switch_close[2])
		else $error("channel one calibration switches open");

	// Resistor codes pass straight through
	a_res_codes: assert property (@(posedge ref_clk) disable iff (!resetn)
		net_ctl.first_resistor_code == res0_r[5:0] && net_ctl.second_resistor_code == res1_r[5:0])
		else $error("resistor code wrong");

	// Amplifier 0 enable and the bandwidth codes 00, 01 and 11
	a_amp0_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
		amp0_ctl.enable == amp0_r[6])
		else $error("amplifier 0 enable wrong");
	a_bw0_slow: assert property (@(posedge ref_clk) disable iff (!resetn)
		amp0_r[1:0] == 2'h0 |-> amp0_ctl.bw_onehot == 4'h1)
		else $error("lowest bandwidth decode wrong");
	a_bw0_mid: assert property (@(posedge ref_clk) disable iff (!resetn)
		amp0_r[1:0] == 2'h1 |-> amp0_ctl.bw_onehot == 4'h2)
		else $error("second bandwidth decode wrong");
	a_bw0_fast: assert property (@(posedge ref_clk) disable iff (!resetn)
		amp0_r[1:0] == 2'h3 |-> amp0_ctl.bw_onehot == 4'h8)
		else $error("highest bandwidth decode wrong");

	// Offset register fields reach both channels
	a_cal_mode_out: assert property (@(posedge ref_clk) disable iff (!resetn)
		amp0_ctl.cal_active == trim0_r[7] && amp1_ctl.cal_active == trim1_r[7])
		else $error("calibration mode output wrong");
	a_cal_ref_out: assert property (@(posedge ref_clk) disable iff (!resetn)
		amp0_ctl.ref_positive == trim0_r[6] && amp1_ctl.ref_positive == trim1_r[6])
		else $error("calibration reference output wrong");
	a_trim1_out: assert property (@(posedge ref_clk) disable iff (!resetn)
		amp1_ctl.trim_code == trim1_r[5:0])
		else $error("channel one trim output wrong");

	// Channel state runs one edge behind its offset register
	a_cal_state1: assert property (@(posedge ref_clk) disable iff (!resetn)
		trim1_r[7] && !trim1_r[6] ##1 trim1_r[7] && !trim1_r[6] |-> st1 == oafe_pkg::OAFE_ST_CALNEG)
		else $error("negative reference state not entered");
	a_normal_state: assert property (@(posedge ref_clk) disable iff (!resetn)
		!trim0_r[7] ##1 !trim0_r[7] |-> st0 == oafe_pkg::OAFE_ST_NORMAL)
		else $error("normal state not held");

	// Status read on the other channel of each pair
	a_status_low1: assert property (@(posedge ref_clk) disable iff (!resetn)
		rd_en && paddr == `OAFE_OFS_AMP1 && !trim1_r[7] |=> prdata_r[5] == 1'b0)
		else $error("channel one status not low in normal mode");
	a_status_follow0: assert property (@(posedge ref_clk) disable iff (!resetn)
		rd_en && paddr == `OAFE_OFS_AMP0 && trim0_r[7] |=> prdata_r[5] == $past(amp_out_raw[0]))
		else $error("channel zero status not following output");

	// Refused writes leave every register as it was
	a_strobe_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_en && !pstrb[0] |=> $stable({sw_r, res0_r, res1_r, amp0_r, amp1_r, trim0_r, trim1_r}))
		else $error("write without byte strobe applied");
	a_unmapped_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_en && !hit |=> $stable({sw_r, res0_r, res1_r, amp0_r, amp1_r, trim0_r, trim1_r}))
		else $error("unmapped write applied");

	// Writes land in their own register, masked to its implemented bits, and nowhere else
	a_switch_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_en && pstrb[0] && paddr == `OAFE_OFS_SWITCH |=> sw_r == ($past(pwdata[7:0]) & `OAFE_MASK_SWITCH))
		else $error("switch write not applied");
	a_res1_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_en && pstrb[0] && paddr == `OAFE_OFS_RES1 |=> res1_r == $past(pwdata[7:0]))
		else $error("second resistor write not applied");
	a_trim0_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_en && pstrb[0] && paddr == `OAFE_OFS_TRIM0 |=> trim0_r == $past(pwdata[7:0]))
		else $error("offset register write not applied");
	a_trim_isolated: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_en && paddr == `OAFE_OFS_TRIM0 |=> $stable({sw_r, res0_r, res1_r, amp0_r, amp1_r, trim1_r}))
		else $error("offset write disturbed another register");

	// Read data: unmapped reads zero, upper bits zero, held between read setups
	a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!resetn)
		rd_en && !hit |=> prdata_r == 32'h00000000)
		else $error("unmapped read not zero");
	a_rdata_upper: assert property (@(posedge ref_clk) disable iff (!resetn)
		prdata_r[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		!rd_en |=> $stable(prdata_r))
		else $error("read data changed outside read setup");

	// Error response only for an unmapped access phase
	a_slverr_map: assert property (@(posedge ref_clk) disable iff (!resetn)
		psel && penable |-> pslverr == !hit)
		else $error("error response wrong");

	// Every other register clears on reset
	a_reset_values: assert property (@(posedge ref_clk) $rose(resetn) |->
		{sw_r, res0_r, res1_r, amp0_r, amp1_r} == 40'h0000000000 && prdata_r == 32'h00000000)
		else $error("register reset value wrong");

	c_strobe_drop: cover property (@(posedge ref_clk) disable iff (!resetn) wr_en && !pstrb[0]);
	c_cal_entry: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(trim0_r[7]));
	c_dc_mode: cover property (@(posedge ref_clk) disable iff (!resetn) sw_r[6:5] == 2'h3);
	c_bad_addr: cover property (@(posedge ref_clk) disable iff (!resetn) pslverr);
	c_stat_read: cover property (@(posedge ref_clk) disable iff (!resetn) rd_en && stat[1]);
endmodule

// ==== tb/optical_afe_control_regs_test.sv ====
`timescale 1ns/1ps
`include "oafe_map.svh"
// Bench for the front-end register bank: APB master, integer model, decode checks
module optical_afe_control_regs_test;
	logic                    ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]             paddr;
	logic [31:0]             pwdata, prdata;
	logic [3:0]              pstrb;
	logic [1:0]              amp_out_raw;
	oafe_pkg::oafe_net_ctl_t net_ctl;
	oafe_pkg::oafe_amp_ctl_t amp0_ctl, amp1_ctl;
	int                      miscompares, num_checks, th;
	logic [7:0]              m [7];
	logic [7:0]              wmask [7] = '{8'h7F, 8'h3F, 8'hFF, 8'h43, 8'h43, 8'hFF, 8'hFF};
	logic [11:0]             ofs [7] = '{`OAFE_OFS_SWITCH, `OAFE_OFS_RES0, `OAFE_OFS_RES1, `OAFE_OFS_AMP0,
	                                     `OAFE_OFS_AMP1, `OAFE_OFS_TRIM0, `OAFE_OFS_TRIM1};

	oafe_regs u_dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.amp_out_raw(amp_out_raw), .net_ctl(net_ctl), .amp0_ctl(amp0_ctl), .amp1_ctl(amp1_ctl));

	// Free-running 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Closing report, also reached by a stuck handshake
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the access phase is held until pready, under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			give_verdict();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Model read value: status bit only live in calibration mode
	function automatic logic [31:0] mrd(int i);
		logic [7:0] v;
		v = m[i];
		if (i == 3 || i == 4) v[5] = m[i + 2][7] & amp_out_raw[i - 3];
		return {24'h000000, v};
	endfunction

	// Upper data bits carry junk that must be dropped
	task automatic wr(int i, logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, ofs[i], ($urandom() & 32'hFFFFFF00) | d, r, e);
		m[i] = d & wmask[i];
	endtask

	task automatic rd(int i, output logic [31:0] r);
		logic e;
		apb(1'b0, ofs[i], 32'h00000000, r, e);
		chk(r, mrd(i));
		chk(e, 1'b0);
	endtask

	// Expected control structs built from the model registers
	task automatic dec();
		oafe_pkg::oafe_net_ctl_t n;
		oafe_pkg::oafe_amp_ctl_t a [2];
		#1;
		n.coupling_onehot = (m[0][6:5] == 2'h1) ? 3'h2 : (m[0][6:5] == 2'h3) ? 3'h4 : 3'h1;
		n.switch_close = m[0][4:0] | ((m[5][7] | m[6][7]) ? 5'h05 : 5'h00);
		n.first_resistor_code = m[1][5:0];
		n.second_resistor_code = m[2][5:0];
		n.third_resistor_onehot = 4'h1 << m[2][7:6];
		for (int k = 0; k < 2; k++) begin
			a[k].enable = m[3 + k][6];
			a[k].bw_onehot = 4'h1 << m[3 + k][1:0];
			a[k].cal_active = m[5 + k][7];
			a[k].ref_positive = m[5 + k][6];
			a[k].trim_code = m[5 + k][5:0];
		end
		chk(net_ctl, n);
		chk(amp0_ctl, a[0]);
		chk(amp1_ctl, a[1]);
	endtask

	task automatic do_reset();
		logic [31:0] r;
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h20};
		for (int i = 0; i < 7; i++) rd(i, r);
		dec();
	endtask

	// Software trim sweep on amplifier 0 against a comparator with threshold th
	task automatic sweep(int start, int step, output int found);
		logic [31:0] r;
		int          v, p;
		v = start;
		p = -1;
		found = -1;
		repeat (64) begin
			wr(5, 8'hC0 | v[5:0]);
			amp_out_raw <= {1'b0, v >= th};
			rd(3, r);
			if (p >= 0 && r[5] != p) begin
				found = v;
				return;
			end
			p = r[5];
			v += step;
		end
	endtask

	// Main sequence
	initial begin
		logic [31:0] r;
		logic        e;
		logic [7:0]  d;
		int          v1, v2;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
		amp_out_raw = 2'h0;
		miscompares = 0;
		num_checks = 0;
		void'($urandom(92));
		do_reset();
		// First passes sweep every mode, bandwidth and third-resistor code; later ones random
		for (int j = 0; j < 8; j++) begin
			amp_out_raw <= 2'($urandom());
			for (int i = 0; i < 7; i++) begin
				d = (j < 4) ? 8'(j * 8'h55) : 8'($urandom());
				if (i == 0 && d[6:5] == 2'h3) d[1] = 1'b0;
				wr(i, d);
				rd(i, r);
			end
			dec();
		end
		// Unmapped place and a write without its byte strobe are refused
		apb(1'b1, 12'h01C, 32'h000000FF, r, e);
		chk(e, 1'b1);
		apb(1'b0, 12'h01C, 32'h00000000, r, e);
		chk(r, 32'h00000000);
		chk(e, 1'b1);
		pstrb <= 4'hE;
		apb(1'b1, ofs[2], {24'h000000, ~m[2]}, r, e);
		pstrb <= 4'hF;
		rd(2, r);
		// Calibration: switches 0 and 2 forced, two endpoints, average restored
		wr(6, 8'h00);
		wr(0, 8'h00);
		wr(3, 8'h40);
		th = 5 + ($urandom() % 50);
		sweep(0, 1, v1);
		dec();
		chk(v1, th);
		sweep(63, -1, v2);
		chk(v2, th - 1);
		wr(5, 8'((v1 + v2) / 2));
		dec();
		chk(amp0_ctl.trim_code, 6'(th - 1));
		amp_out_raw <= 2'h3;
		rd(3, r);
		rd(4, r);
		do_reset();
		give_verdict();
	end
endmodule
